//--- dsr_status_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - The 32-bit monitor word mirrors the monitored value and resets to 0.
// - The selector takes 0 to 127 and picks what is monitored; reset is 0.
// - Flags 0-7: ready, on, zero spd, at spd, in pos, torque, alarm, brake.
// - Flag 8 is homing done, 9 is overload prewarn, 11 to 15 are reserved.
// - Flag 10 is any warning, limit, stop, undervoltage or link error.
// - Renew takes 0 to 2; writing 1 only refreshes the absolute results.
// - Writing 2 also clears the position error, making position the target.
// - Absolute status bit 0 is 1 when the absolute position is lost.
// - Absolute status bit 1 is 1 when the backup battery is low.
// - Absolute status bit 2 is 1 when the multiturn count has overflowed.
// - Absolute status bit 3 is 1 when the user-unit count has overflowed.
// - Absolute status bit 4 is 1 while the coordinate system is not set.
// - Absolute status bits 5 to 15 read zero; the word stays within 0x1f.
// - Turns result: encoder turns when counting pulses, zero in user units.
module dsr_status_regs
(
  input  wire logic                     ref_clk_in,
  input  wire logic                     arst_n_in,
  input  wire dsr_pkg::dsr_req_s        req_in,
  input  wire logic [31:0]              monitor_value_in,
  input  wire dsr_pkg::dsr_drive_cond_s drive_cond_in,
  input  wire dsr_pkg::dsr_abs_cond_s   abs_cond_in,
  input  wire logic [31:0]              encoder_turns_in,
  input  wire logic                     position_source_select_in,
  output dsr_pkg::dsr_rsp_s             rsp_out,
  output logic [15:0]                   monitor_sel_out,
  output logic [15:0]                   status_flags_out,
  output logic                          renew_pulse_out,
  output logic                          pos_err_clear_out
);

  typedef struct packed {
    logic [31:0]       monitor_word;
    logic [15:0]       monitor_sel;
    logic [15:0]       renew_cmd;
    logic [15:0]       abs_status;
    logic [31:0]       abs_turns;
    logic              renew_pulse;
    logic              clear_pulse;
    dsr_pkg::dsr_rsp_s rsp;
  } dsr_reg_state_s;

  dsr_reg_state_s state_ff;
  dsr_reg_state_s nxt_state;
  logic [15:0]    flags_w;
  logic           wr_ok;
  logic           hit;

  ////////////////////////////////////////////////////////////////////////
  // Status flag word assembly.

  // Packs the live drive conditions into the flag word.
  dsr_flag_pack u_flag_pack
  (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .cond_in    (drive_cond_in),
    .flags_out  (flags_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for the parameters and the access answer.

  // Decodes the access, applies writes and builds the one-cycle answer.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.renew_pulse = 1'b0;
    nxt_state.clear_pulse = 1'b0;
    nxt_state.rsp = '0;
    wr_ok = 1'b0;
    hit = 1'b1;
    // The monitor word follows whatever quantity the selector picks.
    nxt_state.monitor_word = monitor_value_in;
    case (req_in.addr)
      dsr_pkg::ADDR_MONITOR_WORD:
        nxt_state.rsp.rdata = state_ff.monitor_word;
      dsr_pkg::ADDR_MONITOR_SEL:
      begin
        nxt_state.rsp.rdata = {16'h0000, state_ff.monitor_sel};
        wr_ok = (req_in.wdata <= {16'h0000, dsr_pkg::MONITOR_SEL_MAX});
        if (req_in.wr && wr_ok)
          nxt_state.monitor_sel = req_in.wdata[15:0];
      end
      dsr_pkg::ADDR_STATUS_FLAGS:
        nxt_state.rsp.rdata = {16'h0000, flags_w};
      dsr_pkg::ADDR_RENEW_CMD:
      begin
        nxt_state.rsp.rdata = {16'h0000, state_ff.renew_cmd};
        wr_ok = (req_in.wdata <= {16'h0000, dsr_pkg::RENEW_AND_CLEAR});
        if (req_in.wr && wr_ok)
        begin
          nxt_state.renew_cmd = req_in.wdata[15:0];
          if (req_in.wdata[15:0] != dsr_pkg::RENEW_NONE)
          begin
            // Refresh the absolute results from the encoder side.
            nxt_state.renew_pulse = 1'b1;
            nxt_state.abs_status =
              {11'h000, abs_cond_in};
            nxt_state.abs_turns =
              position_source_select_in ? 32'h0000_0000
                                        : encoder_turns_in;
          end
          nxt_state.clear_pulse =
            (req_in.wdata[15:0] == dsr_pkg::RENEW_AND_CLEAR);
        end
      end
      dsr_pkg::ADDR_ABS_STATUS:
        nxt_state.rsp.rdata = {16'h0000, state_ff.abs_status};
      dsr_pkg::ADDR_ABS_TURNS:
        nxt_state.rsp.rdata = state_ff.abs_turns;
      default:
        hit = 1'b0;
    endcase
    if (req_in.rd || req_in.wr)
    begin
      nxt_state.rsp.ack = 1'b1;
      // Unmapped addresses and out-of-range or read-only writes are refused.
      nxt_state.rsp.err = !hit || (req_in.wr && !wr_ok);
      if (!req_in.rd)
        nxt_state.rsp.rdata = 32'h0000_0000;
    end
    else
    begin
      nxt_state.rsp.rdata = 32'h0000_0000;
    end
  end

  // Registers the whole state.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_ff.monitor_word <= dsr_pkg::RST_MONITOR_WORD;
      state_ff.monitor_sel  <= dsr_pkg::RST_MONITOR_SEL;
      state_ff.renew_cmd    <= dsr_pkg::RST_RENEW_CMD;
      state_ff.abs_status   <= dsr_pkg::RST_ABS_STATUS;
      state_ff.abs_turns    <= dsr_pkg::RST_ABS_TURNS;
      state_ff.renew_pulse  <= 1'b0;
      state_ff.clear_pulse  <= 1'b0;
      state_ff.rsp          <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state flip-flops; the flag word comes from those of u_flag_pack.
  assign rsp_out           = state_ff.rsp;
  assign monitor_sel_out   = state_ff.monitor_sel;
  assign status_flags_out  = flags_w;
  assign renew_pulse_out   = state_ff.renew_pulse;
  assign pos_err_clear_out = state_ff.clear_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_monitor_mirror;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    req_in.rd && req_in.addr == dsr_pkg::ADDR_MONITOR_WORD
    |=> rsp_out.rdata == $past(monitor_value_in, 2);
  endproperty
  a_monitor_mirror: assert property (p_monitor_mirror)
    else $error("Monitor word does not follow the monitored value.");

  property p_sel_range;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    req_in.wr && req_in.addr == dsr_pkg::ADDR_MONITOR_SEL &&
    req_in.wdata > 32'h0000_007f
    |=> $stable(monitor_sel_out) && rsp_out.err;
  endproperty
  a_sel_range: assert property (p_sel_range)
    else $error("Out-of-range selector write was accepted.");

  property p_low_flags;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    ##1 status_flags_out[7:0] == {$past(drive_cond_in.brake_output_flag),
      $past(drive_cond_in.alarm_flag), $past(drive_cond_in.torque_clamp_flag),
      $past(drive_cond_in.position_done_flag),
      $past(drive_cond_in.velocity_reached_flag),
      $past(drive_cond_in.zero_velocity_flag),
      $past(drive_cond_in.energised_flag),
      $past(drive_cond_in.drive_ready_flag)};
  endproperty
  a_low_flags: assert property (p_low_flags)
    else $error("Low status flags do not match the drive conditions.");

  property p_high_flags;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    drive_cond_in.homing_done_flag && !drive_cond_in.overload_prewarn_flag
    |=> status_flags_out[9:8] == 2'b01 && status_flags_out[15:11] == 5'h00;
  endproperty
  a_high_flags: assert property (p_high_flags)
    else $error("Homing, prewarn or reserved flag bits are wrong.");

  property p_warning;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    (drive_cond_in.emergency_stop || drive_cond_in.comm_error ||
     drive_cond_in.cw_limit) |=> status_flags_out[10];
  endproperty
  a_warning: assert property (p_warning)
    else $error("Warning flag missed a warning condition.");

  property p_renew_only;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    req_in.wr && req_in.addr == dsr_pkg::ADDR_RENEW_CMD &&
    req_in.wdata == 32'h0000_0001
    |=> renew_pulse_out && !pos_err_clear_out ##1 !renew_pulse_out;
  endproperty
  a_renew_only: assert property (p_renew_only)
    else $error("Renew code one gave a wrong pulse pattern.");

  property p_renew_clear;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    req_in.wr && req_in.addr == dsr_pkg::ADDR_RENEW_CMD &&
    req_in.wdata == 32'h0000_0002
    |=> renew_pulse_out && pos_err_clear_out;
  endproperty
  a_renew_clear: assert property (p_renew_clear)
    else $error("Renew code two did not clear the position error.");

  property p_abs_capture;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    renew_pulse_out |-> state_ff.abs_status[4:0] == $past(abs_cond_in);
  endproperty
  a_abs_capture: assert property (p_abs_capture)
    else $error("Absolute status bits do not match the captured state.");

  property p_abs_reserved;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    req_in.rd && req_in.addr == dsr_pkg::ADDR_ABS_STATUS
    |=> rsp_out.rdata <= 32'h0000_001f;
  endproperty
  a_abs_reserved: assert property (p_abs_reserved)
    else $error("Absolute status word exceeds its legal range.");

  property p_turns_puu;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
    renew_pulse_out && $past(position_source_select_in)
    |-> state_ff.abs_turns == 32'h0000_0000;
  endproperty
  a_turns_puu: assert property (p_turns_puu)
    else $error("Turns result is not zero in user-unit mode.");

endmodule : dsr_status_regs

//--- dsr_pkg.sv
package dsr_pkg;

  // Parameter word addresses seen on the communication port.
  localparam logic [15:0] ADDR_MONITOR_WORD = 16'h0058;
  localparam logic [15:0] ADDR_MONITOR_SEL  = 16'h005a;
  localparam logic [15:0] ADDR_STATUS_FLAGS = 16'h005c;
  localparam logic [15:0] ADDR_RENEW_CMD    = 16'h0062;
  localparam logic [15:0] ADDR_ABS_STATUS   = 16'h0064;
  localparam logic [15:0] ADDR_ABS_TURNS    = 16'h0066;

  // Reset values.
  localparam logic [31:0] RST_MONITOR_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_MONITOR_SEL   = 16'h0000;
  localparam logic [15:0] RST_RENEW_CMD     = 16'h0000;
  localparam logic [15:0] RST_ABS_STATUS    = 16'h0000;
  localparam logic [31:0] RST_ABS_TURNS     = 32'h0000_0000;
  localparam logic [15:0] RST_STATUS_FLAGS  = 16'h0000;

  // Legal ranges and renew codes.
  localparam logic [15:0] MONITOR_SEL_MAX   = 16'h007f;
  localparam logic [15:0] RENEW_NONE        = 16'h0000;
  localparam logic [15:0] RENEW_ONLY        = 16'h0001;
  localparam logic [15:0] RENEW_AND_CLEAR   = 16'h0002;

  // Field positions of the status flag word and the absolute field width.
  localparam int FLAG_HOMING_POS  = 8;
  localparam int FLAG_PREWARN_POS = 9;
  localparam int FLAG_WARNING_POS = 10;
  localparam int ABS_FIELD_WIDTH  = 5;

  // Live drive conditions feeding the status flag word.
  typedef struct packed {
    logic drive_ready_flag;
    logic energised_flag;
    logic zero_velocity_flag;
    logic velocity_reached_flag;
    logic position_done_flag;
    logic torque_clamp_flag;
    logic alarm_flag;
    logic brake_output_flag;
    logic homing_done_flag;
    logic overload_prewarn_flag;
    logic drive_warning;
    logic cw_limit;
    logic ccw_limit;
    logic emergency_stop;
    logic undervoltage;
    logic comm_error;
  } dsr_drive_cond_s;

  // Encoder-side absolute conditions, bit 4 down to bit 0.
  typedef struct packed {
    logic coord_unset;
    logic puu_overflow;
    logic multiturn_overflow;
    logic battery_low;
    logic position_lost;
  } dsr_abs_cond_s;

  // Host parameter access request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dsr_req_s;

  // Answer to a parameter access.
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dsr_rsp_s;

endpackage : dsr_pkg

//--- dsr_flag_pack.sv
`timescale 1ns/100ps
module dsr_flag_pack
(
  input  wire logic                     ref_clk_in,
  input  wire logic                     arst_n_in,
  input  wire dsr_pkg::dsr_drive_cond_s cond_in,
  output logic [15:0]                   flags_out
);

  typedef struct packed {
    logic [15:0] flags;
  } dsr_pack_state_s;

  dsr_pack_state_s state_ff;
  dsr_pack_state_s nxt_state;

  // Packs the live conditions into the flag word, reserved bits held low.
  always_comb
  begin
    nxt_state = '0;
    nxt_state.flags[0] = cond_in.drive_ready_flag;
    nxt_state.flags[1] = cond_in.energised_flag;
    nxt_state.flags[2] = cond_in.zero_velocity_flag;
    nxt_state.flags[3] = cond_in.velocity_reached_flag;
    nxt_state.flags[4] = cond_in.position_done_flag;
    nxt_state.flags[5] = cond_in.torque_clamp_flag;
    nxt_state.flags[6] = cond_in.alarm_flag;
    nxt_state.flags[7] = cond_in.brake_output_flag;
    nxt_state.flags[dsr_pkg::FLAG_HOMING_POS] =
      cond_in.homing_done_flag;
    nxt_state.flags[dsr_pkg::FLAG_PREWARN_POS] =
      cond_in.overload_prewarn_flag;
    nxt_state.flags[dsr_pkg::FLAG_WARNING_POS] =
      cond_in.drive_warning | cond_in.cw_limit | cond_in.ccw_limit |
      cond_in.emergency_stop | cond_in.undervoltage |
      cond_in.comm_error;
  end

  // Registers the packed word.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_ff <= '{flags: dsr_pkg::RST_STATUS_FLAGS};
    else
      state_ff <= nxt_state;
  end

  assign flags_out = state_ff.flags;

endmodule : dsr_flag_pack

//--- dsr_host_model.sv
`timescale 1ns/100ps
module dsr_host_model
(
  input  wire logic              ref_clk_in,
  input  wire dsr_pkg::dsr_rsp_s rsp_in,
  output dsr_pkg::dsr_req_s      req_out
);
  ////////////////////////////////////////////////////////////////////////////
  // The port stays idle from time zero until the first access.
  initial req_out = '0;

  ////////////////////////////////////////////////////////////////////////////
  // One access is presented for a single taking edge, then the address and
  // data are inverted so a stale value is never mistaken for a live one.
  task automatic access(input logic rd, input logic wr,
                        input logic [15:0] addr, input logic [31:0] wdata,
                        output logic ok, output int lat, output logic err,
                        output logic [31:0] rdata);
    int n;
    ok    = 1'b0;
    lat   = 0;
    err   = 1'b0;
    rdata = '0;
    @(posedge ref_clk_in);
    req_out <= '{rd: rd, wr: wr, addr: addr, wdata: wdata};
    @(posedge ref_clk_in);
    req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    // The answer is taken at a rising edge, with a bounded wait.
    for (n = 1; n <= 4 && !ok; n++)
    begin
      @(posedge ref_clk_in);
      if (rsp_in.ack === 1'b1)
      begin
        ok    = 1'b1;
        lat   = n;
        err   = rsp_in.err;
        rdata = rsp_in.rdata;
      end
    end
  endtask : access
endmodule : dsr_host_model

//--- drive_status_registers_test.sv
`timescale 1ns/100ps
module drive_status_registers_test;
  logic                     ref_clk_in = 1'b0;
  logic                     arst_n_in  = 1'b0;
  dsr_pkg::dsr_req_s        req;
  dsr_pkg::dsr_rsp_s        rsp;
  logic [31:0]              mon_val    = '0;
  dsr_pkg::dsr_drive_cond_s drv_cond   = '0;
  dsr_pkg::dsr_abs_cond_s   abs_cond   = '0;
  logic [31:0]              enc_turns  = '0;
  logic                     pos_src    = 1'b0;
  logic [15:0]              mon_sel;
  logic [15:0]              flags;
  logic                     renew_pulse;
  logic                     clr_pulse;
  int                       mismatches = 0;
  int                       checks     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  always #5 ref_clk_in = ~ref_clk_in;

  dsr_status_regs i_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .req_in(req), .monitor_value_in(mon_val), .drive_cond_in(drv_cond),
    .abs_cond_in(abs_cond), .encoder_turns_in(enc_turns),
    .position_source_select_in(pos_src), .rsp_out(rsp),
    .monitor_sel_out(mon_sel), .status_flags_out(flags),
    .renew_pulse_out(renew_pulse), .pos_err_clear_out(clr_pulse));

  dsr_host_model i_host (.ref_clk_in(ref_clk_in), .rsp_in(rsp),
    .req_out(req));

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One access with its latency, refusal flag and read data judged.
  task automatic xfer(input logic rd, input logic [15:0] addr,
                      input logic [31:0] wdata, input logic exp_err,
                      input logic [31:0] exp_rd);
    logic        ok;
    int          lat;
    logic        err;
    logic [31:0] rdata;
    i_host.access(rd, !rd, addr, wdata, ok, lat, err, rdata);
    if (!ok)
    begin
      mismatches++;
      $display("Error %0t: no answer at address %h", $time, addr);
      test_done();
    end
    chk("latency", 32'(lat), 32'd1);
    chk("refusal", {31'd0, err}, {31'd0, exp_err});
    chk("read data", rdata, exp_rd);
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  // Every register reads zero after reset; unmapped and read-only refused.
  task automatic t_reset();
    xfer(1, dsr_pkg::ADDR_MONITOR_WORD, '0, 0, '0);
    xfer(1, dsr_pkg::ADDR_MONITOR_SEL, '0, 0, '0);
    xfer(1, dsr_pkg::ADDR_STATUS_FLAGS, '0, 0, '0);
    xfer(1, dsr_pkg::ADDR_RENEW_CMD, '0, 0, '0);
    xfer(1, dsr_pkg::ADDR_ABS_STATUS, '0, 0, '0);
    xfer(1, dsr_pkg::ADDR_ABS_TURNS, '0, 0, '0);
    xfer(1, 16'h0059, '0, 1, '0);
    xfer(0, dsr_pkg::ADDR_MONITOR_WORD, 32'h1, 1, '0);
    xfer(0, dsr_pkg::ADDR_ABS_STATUS, 32'h1, 1, '0);
    xfer(0, dsr_pkg::ADDR_STATUS_FLAGS, 32'h1, 1, '0);
    xfer(0, dsr_pkg::ADDR_ABS_TURNS, 32'h1, 1, '0);
    $display("test reset done");
  endtask : t_reset

  // The monitor word follows the monitored quantity in all 32 bits.
  task automatic t_monitor();
    @(posedge ref_clk_in);
    mon_val <= 32'h89ab_cdef;
    xfer(1, dsr_pkg::ADDR_MONITOR_WORD, '0, 0, 32'h89ab_cdef);
    $display("test monitor done");
  endtask : t_monitor

  // The selector takes 0 to 127 and refuses anything larger.
  task automatic t_select();
    xfer(0, dsr_pkg::ADDR_MONITOR_SEL, 32'h7f, 0, '0);
    chk("selector out", {16'd0, mon_sel}, 32'h7f);
    xfer(0, dsr_pkg::ADDR_MONITOR_SEL, 32'h80, 1, '0);
    xfer(0, dsr_pkg::ADDR_MONITOR_SEL, 32'h0001_0005, 1, '0);
    xfer(1, dsr_pkg::ADDR_MONITOR_SEL, '0, 0, 32'h7f);
    xfer(0, dsr_pkg::ADDR_MONITOR_SEL, 32'h0, 0, '0);
    chk("selector out", {16'd0, mon_sel}, 32'h0);
    $display("test select done");
  endtask : t_select

  // Each condition alone lands on its flag; warning sources share bit 10.
  task automatic t_flags();
    logic [15:0] exp;
    for (int i = 0; i < 16; i++)
    begin
      exp = (i < 10) ? (16'h0001 << i) : 16'h0400;
      @(posedge ref_clk_in);
      drv_cond <= dsr_pkg::dsr_drive_cond_s'(16'h8000 >> i);
      xfer(1, dsr_pkg::ADDR_STATUS_FLAGS, '0, 0, {16'd0, exp});
      chk("flag port", {16'd0, flags}, {16'd0, exp});
    end
    @(posedge ref_clk_in);
    drv_cond <= '0;
    $display("test flags done");
  endtask : t_flags

  // Renew codes 1 and 2, an illegal code, and the absolute snapshots.
  task automatic t_renew();
    @(posedge ref_clk_in);
    abs_cond  <= 5'h15;
    enc_turns <= 32'h0000_1234;
    pos_src   <= 1'b0;
    xfer(0, dsr_pkg::ADDR_RENEW_CMD, 32'h1, 0, '0);
    chk("renew pulse", {31'd0, renew_pulse}, 32'h1);
    chk("clear pulse", {31'd0, clr_pulse}, 32'h0);
    xfer(1, dsr_pkg::ADDR_ABS_STATUS, '0, 0, 32'h15);
    xfer(1, dsr_pkg::ADDR_ABS_TURNS, '0, 0, 32'h1234);
    xfer(1, dsr_pkg::ADDR_RENEW_CMD, '0, 0, 32'h1);
    @(posedge ref_clk_in);
    abs_cond <= 5'h0a;
    pos_src  <= 1'b1;
    xfer(0, dsr_pkg::ADDR_RENEW_CMD, 32'h2, 0, '0);
    chk("renew pulse", {31'd0, renew_pulse}, 32'h1);
    chk("clear pulse", {31'd0, clr_pulse}, 32'h1);
    xfer(1, dsr_pkg::ADDR_ABS_STATUS, '0, 0, 32'h0a);
    xfer(1, dsr_pkg::ADDR_ABS_TURNS, '0, 0, 32'h0);
    @(posedge ref_clk_in);
    abs_cond <= 5'h1f;
    xfer(0, dsr_pkg::ADDR_RENEW_CMD, 32'h3, 1, '0);
    chk("renew pulse", {31'd0, renew_pulse}, 32'h0);
    chk("clear pulse", {31'd0, clr_pulse}, 32'h0);
    xfer(1, dsr_pkg::ADDR_RENEW_CMD, '0, 0, 32'h2);
    xfer(0, dsr_pkg::ADDR_RENEW_CMD, 32'h1, 0, '0);
    xfer(1, dsr_pkg::ADDR_ABS_STATUS, '0, 0, 32'h1f);
    xfer(0, dsr_pkg::ADDR_RENEW_CMD, 32'h0, 0, '0);
    chk("renew pulse", {31'd0, renew_pulse}, 32'h0);
    chk("clear pulse", {31'd0, clr_pulse}, 32'h0);
    xfer(1, dsr_pkg::ADDR_RENEW_CMD, '0, 0, 32'h0);
    $display("test renew done");
  endtask : t_renew

  ////////////////////////////////////////////////////////////////////////////
  // Reset for five cycles, then the scenarios in turn.
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_monitor();
    t_select();
    t_flags();
    t_renew();
    test_done();
  end
endmodule : drive_status_registers_test
